// ===== sgd_direction.sv
// Sensitive ground directional supervision with time, instantaneous and earth fault elements
// How it works
// [R1] Two sensitive ground elements, time delayed and instantaneous, plus restricted earth fault.
// [R2] Own block input inhibits each element; group block inhibits both overcurrent elements.
// [R3] With supervision on, time and instantaneous elements operate only when direction matches permitted direction.
// [R4] Sensitive ground current is always the operating quantity.
// [R5] Voltage polarizing uses minus sum of bus voltages over three; wye only.
// [R6] Voltage mode reports forward when polarizing voltage is below the minimum.
// [R7] Current mode: forward within plus or minus 90 degrees of polarizing current.
// [R8] Current mode defaults forward when polarizing current under 5% CT nominal.
// [R9] Dual mode with weak voltage uses current comparison alone.
// [R10] Dual mode with weak current uses voltage comparison alone.
// [R11] Dual mode with neither quantity adequate reports forward.
// [R12] Dual mode with both valid declares reverse only if both say reverse.
// [R13] Mode select chooses dual, voltage only or current only.
// [R14] Characteristic angle rotates the voltage reference only.
// [R15] Minimum voltage applies to voltage comparison only; default 0.05 of VT.
// [R16] New boot firmware takes polarizing current from ground CT, else dedicated CT.
// [R17] Direction and magnitude checks are recomputed on every processing cycle.
`timescale 1ns/1ps
`include "sgd_params.svh"
module sgd_direction #(
  parameter int PH_W = 16,
  parameter int CNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic sample_valid,
  input wire logic signed [PH_W-1:0] isg_re,
  input wire logic signed [PH_W-1:0] isg_im,
  input wire logic signed [PH_W-1:0] ig_re,
  input wire logic signed [PH_W-1:0] ig_im,
  input wire logic signed [PH_W-1:0] ipol_re,
  input wire logic signed [PH_W-1:0] ipol_im,
  input wire logic signed [PH_W-1:0] va_re,
  input wire logic signed [PH_W-1:0] va_im,
  input wire logic signed [PH_W-1:0] vb_re,
  input wire logic signed [PH_W-1:0] vb_im,
  input wire logic signed [PH_W-1:0] vc_re,
  input wire logic signed [PH_W-1:0] vc_im,
  input wire sgd_pkg::sgd_pol_mode_t polarizing_mode_select,
  input wire logic [31:0] characteristic_angle_setting,
  input wire logic [7:0] min_pol_voltage_pct,
  input wire logic [PH_W-1:0] vt_nominal,
  input wire logic [PH_W-1:0] ct_nominal,
  input wire logic vt_wye,
  input wire logic dir_supervision_en,
  input wire logic permitted_reverse,
  input wire logic [PH_W-1:0] toc_pickup,
  input wire logic [CNT_W-1:0] toc_delay,
  input wire logic [PH_W-1:0] ioc_pickup,
  input wire logic [PH_W-1:0] ref_pickup,
  input wire logic blk_toc_pin,
  input wire logic blk_ioc_pin,
  input wire logic blk_group_pin,
  input wire logic blk_ref_pin,
  input wire logic boot_rev3_pin,
  output logic dir_reverse_r,
  output logic v_pol_ok_r,
  output logic i_pol_ok_r,
  output logic result_valid_r,
  output logic toc_pickup_r,
  output logic toc_operate_r,
  output logic ioc_operate_r,
  output logic ref_operate_r
);
  import sgd_pkg::*;

  localparam int NPIN = 5;
  localparam int VS_W = PH_W + 2;
  localparam int VR_W = VS_W + 3;
  localparam int WIDE = 56;
  localparam int MAG_W = 2 * PH_W + 1;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_r;
  logic [NPIN-1:0] pin_sync_r;
  logic blk_toc_s;
  logic blk_ioc_s;
  logic blk_grp_s;
  logic blk_ref_s;
  logic boot_rev3_s;

  assign pin_raw = {boot_rev3_pin, blk_ref_pin, blk_group_pin, blk_ioc_pin, blk_toc_pin};

  // Two flip-flops per asynchronous pin
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++)
    begin : g_sync
      always_ff @(posedge clk_sys or negedge reset_n)
      begin
        if (!reset_n)
        begin
          pin_meta_r[gi] <= 1'b0;
          pin_sync_r[gi] <= 1'b0;
        end
        else
        begin
          pin_meta_r[gi] <= pin_raw[gi];
          pin_sync_r[gi] <= pin_meta_r[gi];
        end
      end
    end
  endgenerate

  assign blk_toc_s = pin_sync_r[0];
  assign blk_ioc_s = pin_sync_r[1];
  assign blk_grp_s = pin_sync_r[2];
  assign blk_ref_s = pin_sync_r[3];
  assign boot_rev3_s = pin_sync_r[4];

  // ----------------------------------------
  // Stage A: operating and polarizing quantities
  // ----------------------------------------
  logic valid_a_r;
  logic signed [PH_W-1:0] isg_re_a_r;
  logic signed [PH_W-1:0] isg_im_a_r;
  logic signed [PH_W-1:0] ip_re_a_r;
  logic signed [PH_W-1:0] ip_im_a_r;
  logic signed [VS_W-1:0] vpol_re_a_r;
  logic signed [VS_W-1:0] vpol_im_a_r;
  logic signed [VS_W-1:0] vsum_re;
  logic signed [VS_W-1:0] vsum_im;

  // Zero sequence sum of bus voltages; the divide by three is folded into the threshold
  assign vsum_re = VS_W'(va_re) + VS_W'(vb_re) + VS_W'(vc_re);
  assign vsum_im = VS_W'(va_im) + VS_W'(vb_im) + VS_W'(vc_im);

  // Capture one processing cycle of phasors
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      valid_a_r <= 1'b0;
      isg_re_a_r <= '0;
      isg_im_a_r <= '0;
      ip_re_a_r <= '0;
      ip_im_a_r <= '0;
      vpol_re_a_r <= '0;
      vpol_im_a_r <= '0;
    end
    else
    begin
      valid_a_r <= sample_valid; // [R17]
      if (sample_valid)
      begin
        isg_re_a_r <= isg_re; // [R4]
        isg_im_a_r <= isg_im;
        ip_re_a_r <= boot_rev3_s ? ig_re : ipol_re; // [R16]
        ip_im_a_r <= boot_rev3_s ? ig_im : ipol_im;
        vpol_re_a_r <= -vsum_re; // [R5]
        vpol_im_a_r <= -vsum_im;
      end
    end
  end

  // ----------------------------------------
  // Stage B: magnitude checks and angle rotation
  // ----------------------------------------
  logic signed [PH_W-1:0] mta_cos;
  logic signed [PH_W-1:0] mta_sin;
  logic signed [2*VS_W-1:0] vre_sq;
  logic signed [2*VS_W-1:0] vim_sq;
  logic signed [2*PH_W-1:0] ire_sq;
  logic signed [2*PH_W-1:0] iim_sq;
  logic signed [2*PH_W-1:0] ore_sq;
  logic signed [2*PH_W-1:0] oim_sq;
  logic signed [VS_W+PH_W:0] rot_re;
  logic signed [VS_W+PH_W:0] rot_im;
  logic [WIDE-1:0] v_lhs;
  logic [WIDE-1:0] v_rhs;
  logic [WIDE-1:0] i_lhs;
  logic [WIDE-1:0] i_rhs;
  logic [WIDE-1:0] v_lim;
  logic [WIDE-1:0] i_lim;
  logic [7:0] pct_eff;

  assign mta_cos = characteristic_angle_setting[`SGD_MTA_COS_MSB:`SGD_MTA_COS_LSB];
  assign mta_sin = characteristic_angle_setting[`SGD_MTA_SIN_MSB:`SGD_MTA_SIN_LSB];
  assign vre_sq = vpol_re_a_r * vpol_re_a_r;
  assign vim_sq = vpol_im_a_r * vpol_im_a_r;
  assign ire_sq = ip_re_a_r * ip_re_a_r;
  assign iim_sq = ip_im_a_r * ip_im_a_r;
  assign ore_sq = isg_re_a_r * isg_re_a_r;
  assign oim_sq = isg_im_a_r * isg_im_a_r;

  // Reference leads polarizing voltage by the characteristic angle
  assign rot_re = (VS_W+PH_W+1)'(vpol_re_a_r * mta_cos) - (VS_W+PH_W+1)'(vpol_im_a_r * mta_sin); // [R14]
  assign rot_im = (VS_W+PH_W+1)'(vpol_re_a_r * mta_sin) + (VS_W+PH_W+1)'(vpol_im_a_r * mta_cos);

  // Zero setting selects the default minimum polarizing voltage
  assign pct_eff = (min_pol_voltage_pct == 8'h00) ? 8'(`SGD_MIN_POL_PCT_DEFAULT) : min_pol_voltage_pct; // [R15]

  // 10000*|sum|^2 against (3*pct*VT)^2, avoiding any divide
  assign v_lhs = WIDE'(`SGD_PCT_SQ) * (WIDE'(unsigned'(vre_sq)) + WIDE'(unsigned'(vim_sq)));
  assign v_lim = WIDE'(`SGD_ZS_DIV) * WIDE'(pct_eff) * WIDE'(vt_nominal);
  assign v_rhs = v_lim * v_lim;
  // 10000*|Ipol|^2 against (5*CT)^2
  assign i_lhs = WIDE'(`SGD_PCT_SQ) * (WIDE'(unsigned'(ire_sq)) + WIDE'(unsigned'(iim_sq)));
  assign i_lim = WIDE'(`SGD_CT_MIN_PCT) * WIDE'(ct_nominal);
  assign i_rhs = i_lim * i_lim;

  logic valid_b_r;
  logic v_ok_b_r;
  logic i_ok_b_r;
  logic [MAG_W-1:0] op_mag_b_r;
  logic signed [PH_W-1:0] isg_re_b_r;
  logic signed [PH_W-1:0] isg_im_b_r;
  logic signed [PH_W-1:0] ip_re_b_r;
  logic signed [PH_W-1:0] ip_im_b_r;
  logic signed [VR_W-1:0] vref_re_b_r;
  logic signed [VR_W-1:0] vref_im_b_r;

  // Register validity flags and comparator inputs
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      valid_b_r <= 1'b0;
      v_ok_b_r <= 1'b0;
      i_ok_b_r <= 1'b0;
      op_mag_b_r <= '0;
      isg_re_b_r <= '0;
      isg_im_b_r <= '0;
      ip_re_b_r <= '0;
      ip_im_b_r <= '0;
      vref_re_b_r <= '0;
      vref_im_b_r <= '0;
    end
    else
    begin
      valid_b_r <= valid_a_r;
      if (valid_a_r)
      begin
        v_ok_b_r <= vt_wye && (v_lhs >= v_rhs); // [R5] [R6]
        i_ok_b_r <= (i_lhs >= i_rhs); // [R8]
        op_mag_b_r <= MAG_W'(unsigned'(ore_sq)) + MAG_W'(unsigned'(oim_sq));
        isg_re_b_r <= isg_re_a_r;
        isg_im_b_r <= isg_im_a_r;
        ip_re_b_r <= ip_re_a_r;
        ip_im_b_r <= ip_im_a_r;
        vref_re_b_r <= rot_re[VS_W+PH_W:`SGD_ANGLE_FRAC];
        vref_im_b_r <= rot_im[VS_W+PH_W:`SGD_ANGLE_FRAC];
      end
    end
  end

  // ----------------------------------------
  // Stage C: phase comparisons
  // ----------------------------------------
  logic fwd_v_c;
  logic fwd_i_c;
  logic valid_c_r;
  logic v_ok_c_r;
  logic i_ok_c_r;
  logic [MAG_W-1:0] op_mag_c_r;

  sgd_angle_cmp #(.OP_W(PH_W), .REF_W(VR_W)) u_cmp_volt (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .valid_in(valid_b_r),
    .op_re(isg_re_b_r),
    .op_im(isg_im_b_r),
    .ref_re(vref_re_b_r),
    .ref_im(vref_im_b_r),
    .fwd_r(fwd_v_c)
  );

  sgd_angle_cmp #(.OP_W(PH_W), .REF_W(PH_W)) u_cmp_curr (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .valid_in(valid_b_r),
    .op_re(isg_re_b_r),
    .op_im(isg_im_b_r),
    .ref_re(ip_re_b_r),
    .ref_im(ip_im_b_r),
    .fwd_r(fwd_i_c)
  );

  // Carry flags alongside the comparator results
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      valid_c_r <= 1'b0;
      v_ok_c_r <= 1'b0;
      i_ok_c_r <= 1'b0;
      op_mag_c_r <= '0;
    end
    else
    begin
      valid_c_r <= valid_b_r;
      if (valid_b_r)
      begin
        v_ok_c_r <= v_ok_b_r;
        i_ok_c_r <= i_ok_b_r;
        op_mag_c_r <= op_mag_b_r;
      end
    end
  end

  // ----------------------------------------
  // Stage D: direction decision and elements
  // ----------------------------------------
  // Reverse only from an adequate quantity; weak quantities fall back to forward
  function automatic logic sgd_decide(input sgd_pol_mode_t mode, input logic v_ok, input logic fwd_v,
                                      input logic i_ok, input logic fwd_i);
    logic v_rev;
    logic i_rev;
    v_rev = v_ok && !fwd_v;
    i_rev = i_ok && !fwd_i;
    case (mode) // [R13]
      SGD_POL_VOLT: sgd_decide = v_rev; // [R6]
      SGD_POL_CURR: sgd_decide = i_rev; // [R7] [R8]
      default:
      begin
        if (v_ok && i_ok)
          sgd_decide = v_rev && i_rev; // [R12]
        else if (i_ok)
          sgd_decide = i_rev; // [R9]
        else if (v_ok)
          sgd_decide = v_rev; // [R10]
        else
          sgd_decide = 1'b0; // [R11]
      end
    endcase
  endfunction

  logic rev_nxt;
  logic permit_nxt;
  logic toc_pick_nxt;
  logic ioc_nxt;
  logic ref_nxt;

  // Element decisions for the current processing cycle
  always_comb
  begin
    rev_nxt = sgd_decide(polarizing_mode_select, v_ok_c_r, fwd_v_c, i_ok_c_r, fwd_i_c);
    permit_nxt = !dir_supervision_en || (rev_nxt == permitted_reverse); // [R3]
    toc_pick_nxt = permit_nxt && !blk_toc_s && !blk_grp_s &&
                   (op_mag_c_r > MAG_W'(toc_pickup * toc_pickup)); // [R2]
    ioc_nxt = permit_nxt && !blk_ioc_s && !blk_grp_s &&
              (op_mag_c_r > MAG_W'(ioc_pickup * ioc_pickup)); // [R2]
    ref_nxt = !blk_ref_s && (op_mag_c_r > MAG_W'(ref_pickup * ref_pickup)); // [R1]
  end

  // Direction and status outputs
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dir_reverse_r <= 1'b0;
      v_pol_ok_r <= 1'b0;
      i_pol_ok_r <= 1'b0;
      result_valid_r <= 1'b0;
    end
    else
    begin
      result_valid_r <= valid_c_r; // [R17]
      if (valid_c_r)
      begin
        dir_reverse_r <= rev_nxt;
        v_pol_ok_r <= v_ok_c_r;
        i_pol_ok_r <= i_ok_c_r;
      end
    end
  end

  // Instantaneous and restricted earth fault elements
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ioc_operate_r <= 1'b0;
      ref_operate_r <= 1'b0;
    end
    else if (valid_c_r)
    begin
      ioc_operate_r <= ioc_nxt; // [R1]
      ref_operate_r <= ref_nxt;
    end
  end

  // Definite delay time overcurrent, counted in processing cycles
  sgd_toc_state_t toc_state_r;
  logic [CNT_W-1:0] toc_cnt_r;

  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      toc_state_r <= SGD_TOC_IDLE;
      toc_cnt_r <= CNT_W'(`SGD_CNT_RESET);
      toc_pickup_r <= 1'b0;
      toc_operate_r <= 1'b0;
    end
    else if (valid_c_r)
    begin
      toc_pickup_r <= toc_pick_nxt;
      toc_operate_r <= 1'b0;
      if (!toc_pick_nxt)
      begin
        toc_state_r <= SGD_TOC_IDLE; // [R1]
        toc_cnt_r <= CNT_W'(`SGD_CNT_RESET);
      end
      else
      begin
        case (toc_state_r)
          SGD_TOC_IDLE:
          begin
            toc_state_r <= SGD_TOC_TIMING;
            toc_cnt_r <= CNT_W'(`SGD_CNT_RESET);
          end
          SGD_TOC_TIMING:
          begin
            if (toc_cnt_r >= toc_delay)
            begin
              toc_state_r <= SGD_TOC_OPERATED;
              toc_operate_r <= 1'b1;
            end
            else
            begin
              toc_cnt_r <= toc_cnt_r + 1'b1;
            end
          end
          default:
          begin
            toc_operate_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  sequence s_sample;
    sample_valid;
  endsequence

  sequence s_result;
    ##4 result_valid_r;
  endsequence

  pipe_latency_a: assert property (s_sample |-> s_result) // [R17]
    else $error("result not four cycles after sample");

  volt_weak_fwd_a: assert property (valid_c_r && polarizing_mode_select == SGD_POL_VOLT && !v_ok_c_r
    |=> !dir_reverse_r) // [R6]
    else $error("weak voltage did not give forward");

  curr_weak_fwd_a: assert property (valid_c_r && polarizing_mode_select == SGD_POL_CURR && !i_ok_c_r
    |=> !dir_reverse_r) // [R8]
    else $error("weak current did not give forward");

  dual_none_fwd_a: assert property (valid_c_r && polarizing_mode_select == SGD_POL_DUAL && !v_ok_c_r
    && !i_ok_c_r |=> !dir_reverse_r) // [R11]
    else $error("dual with no quantity did not give forward");

  dual_agree_a: assert property (valid_c_r && polarizing_mode_select == SGD_POL_DUAL && v_ok_c_r
    && i_ok_c_r |=> dir_reverse_r == ($past(!fwd_v_c) && $past(!fwd_i_c))) // [R12]
    else $error("dual reverse without agreement");

  dual_curr_only_a: assert property (valid_c_r && polarizing_mode_select == SGD_POL_DUAL && !v_ok_c_r
    && i_ok_c_r |=> dir_reverse_r == $past(!fwd_i_c)) // [R9]
    else $error("dual weak voltage not current decided");

  dual_volt_only_a: assert property (valid_c_r && polarizing_mode_select == SGD_POL_DUAL && v_ok_c_r
    && !i_ok_c_r |=> dir_reverse_r == $past(!fwd_v_c)) // [R10]
    else $error("dual weak current not voltage decided");

  group_block_a: assert property (valid_c_r && blk_grp_s |=> !ioc_operate_r && !toc_operate_r
    && !toc_pickup_r) // [R2]
    else $error("group block did not inhibit elements");

  dir_gate_a: assert property (result_valid_r && $past(dir_supervision_en)
    && dir_reverse_r != $past(permitted_reverse) |-> !ioc_operate_r && !toc_operate_r) // [R3]
    else $error("element operated in wrong direction");

endmodule // sgd_direction

// ===== sgd_params.svh
// Constants for the sensitive ground direction logic
`ifndef SGD_PARAMS_SVH
`define SGD_PARAMS_SVH

// ----------------------------------------
// Characteristic angle field positions (Q1.14 unit vector)
// ----------------------------------------
`define SGD_MTA_COS_MSB 31
`define SGD_MTA_COS_LSB 16
`define SGD_MTA_SIN_MSB 15
`define SGD_MTA_SIN_LSB 0
`define SGD_ANGLE_FRAC 14

// ----------------------------------------
// Magnitude thresholds
// ----------------------------------------
`define SGD_ZS_DIV 3
`define SGD_PCT_SQ 10000
`define SGD_CT_MIN_PCT 5
`define SGD_MIN_POL_PCT_DEFAULT 5

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SGD_CNT_RESET 0

`endif

// ===== sgd_pkg.sv
// Types shared by the sensitive ground direction logic
package sgd_pkg;

  // Polarizing mode choices
  typedef enum logic [1:0] {
    SGD_POL_DUAL = 2'h0,
    SGD_POL_VOLT = 2'h1,
    SGD_POL_CURR = 2'h2
  } sgd_pol_mode_t;

  // Time overcurrent element states
  typedef enum logic [1:0] {
    SGD_TOC_IDLE,
    SGD_TOC_TIMING,
    SGD_TOC_OPERATED
  } sgd_toc_state_t;

endpackage

// ===== sgd_angle_cmp.sv
// Half-plane phase comparator: forward when operating phasor is within 90 degrees of reference
`timescale 1ns/1ps
`include "sgd_params.svh"
module sgd_angle_cmp #(
  parameter int OP_W = 16,
  parameter int REF_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic valid_in,
  input wire logic signed [OP_W-1:0] op_re,
  input wire logic signed [OP_W-1:0] op_im,
  input wire logic signed [REF_W-1:0] ref_re,
  input wire logic signed [REF_W-1:0] ref_im,
  output logic fwd_r
);
  import sgd_pkg::*;

  localparam int DOT_W = OP_W + REF_W + 1;

  logic signed [OP_W+REF_W-1:0] prod_re;
  logic signed [OP_W+REF_W-1:0] prod_im;
  logic signed [DOT_W-1:0] dot;

  // Real part of op times conjugate of reference
  assign prod_re = op_re * ref_re;
  assign prod_im = op_im * ref_im;
  assign dot = DOT_W'(prod_re) + DOT_W'(prod_im);

  // Non-negative projection means within plus or minus 90 degrees
  always_ff @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      fwd_r <= 1'b1;
    end
    else if (valid_in)
    begin
      fwd_r <= (dot >= 0); // [R7]
    end
  end

endmodule // sgd_angle_cmp

// ===== sgd_meas_model.sv
// Measurement front end model that hands phasor samples to the direction logic
`timescale 1ns/1ps
module sgd_meas_model (
  input wire logic clk_sys,
  output logic sample_valid,
  output logic signed [15:0] ph [12]
);
  logic signed [15:0] last [12];

  // Lines start quiet
  initial
  begin
    sample_valid = 1'b0;
    foreach (ph[k]) ph[k] = 16'h0000;
    foreach (last[k]) last[k] = 16'h0000;
  end

  // Present one sample for a single cycle, just after the edge
  task automatic put(input logic signed [15:0] v [12]);
    @(posedge clk_sys);
    #1;
    ph = v;
    last = v;
    sample_valid = 1'b1;
  endtask

  // Between samples the lines carry the inverse of the last value
  task automatic idle();
    @(posedge clk_sys);
    #1;
    sample_valid = 1'b0;
    foreach (ph[k]) ph[k] = ~last[k];
  endtask
endmodule // sgd_meas_model

// ===== tb_sgd_direction.sv
// Self-checking bench for the sensitive ground direction logic
`timescale 1ns/1ps
module tb_sgd_direction;
  import sgd_pkg::*;
  // ----------------------------------------
  // Stimulus and observation signals
  // ----------------------------------------
  logic [15:0] vt_nom = 16'h03E8, ct_nom = 16'h0190;
  localparam logic [31:0] ANG [4] = '{32'h4000_0000, 32'h0000_4000, 32'h2D41_2D41, 32'hD2BF_2D41};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic sample_valid;
  logic signed [15:0] ph [12];
  sgd_pol_mode_t mode = SGD_POL_DUAL;
  logic [31:0] angle = 32'h4000_0000;
  logic [7:0] pct = 8'h00;
  logic wye = 1'b1, sup_en = 1'b0, perm_rev = 1'b0, boot = 1'b0;
  logic b_toc = 1'b0, b_ioc = 1'b0, b_grp = 1'b0, b_ref = 1'b0;
  logic [15:0] toc_pk = 16'h0000, ioc_pk = 16'h0000, ref_pk = 16'h0000, dly = 16'h0000;
  logic rev, vok, iok, rvalid, tpk, top, ioc, refo;
  logic [6:0] exp_q [$];
  logic [6:0] want;
  int cyc_q [$];
  int cyc = 0, c0 = 0, mismatches = 0, n_checks = 0, toc_n = 0, seed = 32'h41BD;

  // Free running clock
  always #5 clk_sys = ~clk_sys;

  sgd_meas_model meas_inst (.clk_sys(clk_sys), .sample_valid(sample_valid), .ph(ph));

  sgd_direction #(.PH_W(16), .CNT_W(16)) sgd_direction_inst (
    .clk_sys(clk_sys), .reset_n(reset_n), .sample_valid(sample_valid),
    .isg_re(ph[0]), .isg_im(ph[1]), .ig_re(ph[2]), .ig_im(ph[3]), .ipol_re(ph[4]), .ipol_im(ph[5]),
    .va_re(ph[6]), .va_im(ph[7]), .vb_re(ph[8]), .vb_im(ph[9]), .vc_re(ph[10]), .vc_im(ph[11]),
    .polarizing_mode_select(mode), .characteristic_angle_setting(angle), .min_pol_voltage_pct(pct),
    .vt_nominal(vt_nom), .ct_nominal(ct_nom), .vt_wye(wye), .dir_supervision_en(sup_en),
    .permitted_reverse(perm_rev), .toc_pickup(toc_pk), .toc_delay(dly), .ioc_pickup(ioc_pk),
    .ref_pickup(ref_pk), .blk_toc_pin(b_toc), .blk_ioc_pin(b_ioc), .blk_group_pin(b_grp),
    .blk_ref_pin(b_ref), .boot_rev3_pin(boot), .dir_reverse_r(rev), .v_pol_ok_r(vok),
    .i_pol_ok_r(iok), .result_valid_r(rvalid), .toc_pickup_r(tpk), .toc_operate_r(top),
    .ioc_operate_r(ioc), .ref_operate_r(refo)
  );

  // ----------------------------------------
  // Comparison and verdict
  // ----------------------------------------
  task automatic chk(input logic [6:0] seen, input logic [6:0] exp_v, input string what);
    n_checks++;
    if (seen !== exp_v)
    begin
      mismatches++;
      $display("[ERR] %0t %s seen %b want %b", $time, what, seen, exp_v);
    end
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Reference model of one sample
  // ----------------------------------------
  task automatic sample();
    logic signed [15:0] v [12];
    int sh [4];
    longint vr, vi, ir, ii, rr, ri, m, c, s, tv;
    logic fv, fi, vk, ik, rv, pm, tp;
    foreach (sh[g]) sh[g] = $random(seed) & 7;
    foreach (v[k]) v[k] = 16'(($random(seed) % 8192) >>> sh[k < 6 ? k / 2 : 3]);
    meas_inst.put(v);
    vr = -(longint'(v[6]) + v[8] + v[10]);
    vi = -(longint'(v[7]) + v[9] + v[11]);
    ir = boot ? v[2] : v[4];
    ii = boot ? v[3] : v[5];
    c = $signed(angle[31:16]);
    s = $signed(angle[15:0]);
    rr = (vr * c - vi * s) >>> 14;
    ri = (vr * s + vi * c) >>> 14;
    tv = (pct == 0) ? 5 : pct;
    tv = 3 * tv * longint'(vt_nom);
    vk = wye && 10000 * (vr * vr + vi * vi) >= tv * tv;
    ik = 10000 * (ir * ir + ii * ii) >= 25 * longint'(ct_nom) * ct_nom;
    fv = v[0] * rr + v[1] * ri >= 0;
    fi = v[0] * ir + v[1] * ii >= 0;
    case (mode)
      SGD_POL_VOLT: rv = vk & !fv;
      SGD_POL_CURR: rv = ik & !fi;
      default: rv = (vk & ik) ? (!fv & !fi) : (vk ? !fv : ik & !fi);
    endcase
    pm = !sup_en || rv == perm_rev;
    m = v[0] * v[0] + v[1] * v[1];
    tp = pm && !b_toc && !b_grp && m > toc_pk * toc_pk;
    toc_n = tp ? toc_n + 1 : 0;
    exp_q.push_back({rv, vk, ik, tp, toc_n >= dly + 2, pm && !b_ioc && !b_grp && m > ioc_pk * ioc_pk,
                     !b_ref && m > ref_pk * ref_pk});
    cyc_q.push_back(cyc);
  endtask

  // Compare each result with the oldest expectation
  always @(posedge clk_sys)
  begin
    cyc++;
    #2;
    if (rvalid === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(7'h01, 7'h00, "unexpected result");
      else
      begin
        want = exp_q.pop_front();
        c0 = cyc_q.pop_front();
        // Counted from the edge that launches the sample, one before the design takes it
        chk(7'(cyc - c0), 7'h04, "latency");
        chk({6'h00, rev}, {6'h00, want[6]}, "direction");
        chk({5'h00, vok, iok}, {5'h00, want[5:4]}, "polarizing ok");
        chk({3'h0, tpk, top, ioc, refo}, {3'h0, want[3:0]}, "elements");
      end
    end
  end

  // ----------------------------------------
  // Main sequence: random settings, then samples with random idle gaps
  // ----------------------------------------
  initial
  begin
    repeat (3) @(posedge clk_sys);
    #1;
    reset_n = 1'b1;
    for (int i = 0; i < 40; i++)
    begin
      repeat (5) meas_inst.idle();
      mode = sgd_pol_mode_t'(i % 4);
      boot = 1'($random(seed));
      wye = ($random(seed) & 7) != 0;
      sup_en = 1'($random(seed));
      perm_rev = 1'($random(seed));
      angle = ANG[$random(seed) & 3];
      pct = (i % 3 == 0) ? 8'h00 : 8'(2 + ($random(seed) & 15));
      vt_nom = 16'(300 + ($random(seed) & 2047));
      ct_nom = 16'(50 + ($random(seed) & 511));
      {b_toc, b_ioc, b_grp, b_ref} = 4'($random(seed) & $random(seed) & $random(seed));
      toc_pk = (i % 2 == 0) ? 16'h0000 : 16'($random(seed) & 1023);
      ioc_pk = 16'($random(seed) & 4095);
      ref_pk = 16'($random(seed) & 4095);
      dly = 16'($random(seed) & 3);
      repeat (5) meas_inst.idle();
      for (int j = 0; j < 16; j++)
        if (($random(seed) & 3) == 0)
          meas_inst.idle();
        else
          sample();
      $display("test %0d done", i);
    end
    repeat (8) meas_inst.idle();
    chk(7'(exp_q.size()), 7'h00, "results outstanding");
    results();
  end

  // Watchdog against a hang
  initial
  begin
    #50000;
    mismatches++;
    results();
  end
endmodule // tb_sgd_direction
